// [include/pq_pkg.sv]
// shared types and constants of the product/quotient unit
package pq_pkg;

    localparam int DATA_W       = 32;
    // latency figures below are counted in pipeline clocks
    localparam int MUL_LAT_CYC  = 5;
    localparam int ITER_LAT_CYC = 34;
    localparam int FULL_ITERS   = 32;
    localparam int SKIP_8       = 23;
    localparam int SKIP_16      = 15;
    localparam int SKIP_24      = 7;
    localparam int CNT_W        = 6;

    typedef enum logic [2:0]
    {
        full_product_op       = 3'h0,
        product_accumulate_op = 3'h1,
        product_deduct_op     = 3'h2,
        quotient_op           = 3'h3,
        gpr_product_op        = 3'h4
    } op_t;

    typedef enum logic [2:0]
    {
        st_idle = 3'h1,
        st_iter = 3'h2,
        st_fix  = 3'h4
    } fsm_t;

    typedef struct packed
    {
        logic                valid;
        op_t                 op;
        logic                is_signed;
        logic [DATA_W-1:0]   dividend_operand;
        logic [DATA_W-1:0]   second_operand;
    } issue_t;

    typedef struct packed
    {
        logic                valid;
        logic [DATA_W-1:0]   data;
    } gpr_t;

    typedef struct packed
    {
        logic                valid;
        op_t                 op;
        logic [2*DATA_W-1:0] prod;
    } pipe_t;

    typedef struct packed
    {
        fsm_t                state;
        logic [CNT_W-1:0]    cnt;
        logic [DATA_W:0]     rem;
        logic [DATA_W-1:0]   quo;
        logic [DATA_W-1:0]   opnd;
        logic                neg_main;
        logic                neg_rem;
        op_t                 op;
        logic [DATA_W-1:0]   upper_result_reg;
        logic [DATA_W-1:0]   bottom_result_reg;
        gpr_t                gpr;
        logic                done;
    } pq_state_t;

endpackage

// [hdl/product_pipe.sv]
// pipelined 32x32 multiplier feeding the result stage
module product_pipe
#(
    parameter int STAGES = pq_pkg::MUL_LAT_CYC - 1
)
(
    input  wire logic           mclk_i,
    input  wire logic           rst_n_i,
    input  wire logic           valid_i,
    input  wire pq_pkg::op_t    op_i,
    input  wire logic           is_signed_i,
    input  wire logic [31:0]    a_i,
    input  wire logic [31:0]    b_i,
    output pq_pkg::pipe_t       out_o
);
    import pq_pkg::*;

    pipe_t [STAGES-1:0] pipe_reg;
    pipe_t [STAGES-1:0] pipe_next;
    logic signed [65:0] full_prod;

    if (STAGES < 1)
    begin : g_bad_stages
        $error("product_pipe needs at least one stage");
    end

    // signed and unsigned share one 33x33 array by extending the sign bit
    assign full_prod = $signed({is_signed_i & a_i[31], a_i})
                     * $signed({is_signed_i & b_i[31], b_i});

    // stage 0 multiplies, later stages only carry the product along
    always_comb
    begin
        pipe_next[0].valid = valid_i;
        pipe_next[0].op    = op_i;
        pipe_next[0].prod  = full_prod[63:0];
        for (int i = 1; i < STAGES; i++)
        begin
            pipe_next[i] = pipe_reg[i-1];
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            pipe_reg <= '0;
        else
            pipe_reg <= pipe_next;
    end

    assign out_o = pipe_reg[STAGES-1];

    // every accepted product leaves after exactly STAGES clocks
    property p_pipe_depth;
        @(posedge mclk_i) disable iff (!rst_n_i)
        valid_i |-> ##STAGES out_o.valid;
    endproperty
    a_pipe_depth: assert property (p_pipe_depth)
        else $error("product left the pipe at the wrong time");

endmodule

// [hdl/product_quotient_unit.sv]
// product/quotient unit: upper/bottom result pair, multiplier, divider
// How it works
// - the unit has its own pipeline and keeps advancing whatever the integer pipe does.
// - it holds a pipelined 32x32 multiplier, upper and bottom result registers and a divide engine.
// - the standard unit takes a new multiply, accumulate or deduct every clock.
// - products bound for a general register may issue on back-to-back clocks.
// - divides resolve one quotient bit per clock.
// - dividends that fit 8, 16 or 24 bits skip 23, 15 or 7 iterations.
// - any new issue while a divide runs is stalled until it completes.
// - the reduced-area build does multiplies and divides one bit per clock in 34 clocks.
// - latency and repeat figures are counted in pipeline clocks.
// - a standard 32-bit multiply has its result five clocks after issue.
// - the reduced-area build refuses signal-processing or user result access.
module product_quotient_unit
#(
    parameter bit ITERATIVE_ONLY     = 1'b0,
    parameter bit SIMD_EXT_EN        = 1'b0,
    parameter bit USER_RESULT_ACCESS = 1'b0
)
(
    input  wire logic           mclk_i,
    input  wire logic           rst_n_i,
    input  wire pq_pkg::issue_t issue_i,
    output logic                stall_o,
    output logic                busy_o,
    output logic [31:0]         upper_result_o,
    output logic [31:0]         bottom_result_o,
    output pq_pkg::gpr_t        gpr_result_o,
    output logic                done_o
);
    import pq_pkg::*;

    pq_state_t s_reg;
    pq_state_t s_next;
    pipe_t     pipe_out;
    logic      accept;
    logic      pipe_take;

    if (ITERATIVE_ONLY && (SIMD_EXT_EN || USER_RESULT_ACCESS))
    begin : g_bad_build
        $error("iterative build cannot expose result registers");
    end

    // magnitude of an operand, used by both iterative engines
    function automatic logic [31:0] mag(logic [31:0] v, logic sgn);
        mag = (sgn && v[31]) ? 32'(-v) : v;
    endfunction

    // early-in skip from the dividend sign extension
    function automatic logic [5:0] early_skip(logic [31:0] v, logic sgn);
        logic ext;
        ext = sgn & v[31];
        // unsigned values need only zeros above the width, signed ones
        // also need the top kept bit to match the sign
        if (v[31:8] == {24{ext}} && (!sgn || v[7] == ext))
            early_skip = 6'(SKIP_8);
        else if (v[31:16] == {16{ext}} && (!sgn || v[15] == ext))
            early_skip = 6'(SKIP_16);
        else if (v[31:24] == {8{ext}} && (!sgn || v[23] == ext))
            early_skip = 6'(SKIP_24);
        else
            early_skip = 6'h00;
    endfunction

    // fold a product into the register pair
    function automatic logic [63:0] fold(op_t op, logic [63:0] prod,
                                         logic [63:0] pair);
        case (op)
            product_accumulate_op: fold = pair + prod;
            product_deduct_op:     fold = pair - prod;
            default:               fold = prod;
        endcase
    endfunction

    // stall any issue while the iterative engine is busy
    assign busy_o    = (s_reg.state != st_idle);
    assign stall_o   = issue_i.valid && busy_o;
    assign accept    = issue_i.valid && !busy_o;
    // the pipe takes a product every clock in the standard build
    assign pipe_take = accept && !ITERATIVE_ONLY
                       && (issue_i.op != quotient_op);

    // pipelined multiplier, four stages plus the result stage
    product_pipe #(
        .STAGES (MUL_LAT_CYC - 1)
    ) u_pipe (
        .mclk_i      (mclk_i),
        .rst_n_i     (rst_n_i),
        .valid_i     (pipe_take),
        .op_i        (issue_i.op),
        .is_signed_i (issue_i.is_signed),
        .a_i         (issue_i.dividend_operand),
        .b_i         (issue_i.second_operand),
        .out_o       (pipe_out)
    );

    // next state: pipe writeback first, iterative engine may override
    always_comb
    begin
        logic [33:0] trial;
        logic [32:0] sum;
        logic [63:0] prod;
        logic [5:0]  skip;
        trial = '0;
        sum   = '0;
        prod  = '0;
        skip  = '0;
        s_next           = s_reg;
        s_next.done      = 1'b0;
        s_next.gpr.valid = 1'b0;
        // result stage five clocks after issue
        if (pipe_out.valid)
        begin
            if (pipe_out.op == gpr_product_op)
            begin
                // general register result, no pair update
                s_next.gpr.valid = 1'b1;
                s_next.gpr.data  = pipe_out.prod[31:0];
            end
            else
            begin
                {s_next.upper_result_reg, s_next.bottom_result_reg} =
                    fold(pipe_out.op, pipe_out.prod,
                         {s_reg.upper_result_reg, s_reg.bottom_result_reg});
            end
        end
        // engine advances on every clock, no outside hold
        case (s_reg.state)
            st_idle:
            begin
                if (accept && (ITERATIVE_ONLY || issue_i.op == quotient_op))
                begin
                    s_next.state   = st_iter;
                    s_next.op      = issue_i.op;
                    s_next.rem     = '0;
                    s_next.neg_rem = issue_i.is_signed
                                     && issue_i.dividend_operand[31];
                    s_next.neg_main = issue_i.is_signed
                        && (issue_i.dividend_operand[31]
                            ^ issue_i.second_operand[31]);
                    if (issue_i.op == quotient_op)
                    begin
                        skip = ITERATIVE_ONLY ? 6'h00
                             : early_skip(issue_i.dividend_operand,
                                          issue_i.is_signed);
                        s_next.quo  = mag(issue_i.dividend_operand,
                                          issue_i.is_signed) << skip;
                        s_next.opnd = mag(issue_i.second_operand,
                                          issue_i.is_signed);
                        s_next.cnt  = CNT_W'(FULL_ITERS) - skip;
                    end
                    else
                    begin
                        s_next.quo  = mag(issue_i.second_operand,
                                          issue_i.is_signed);
                        s_next.opnd = mag(issue_i.dividend_operand,
                                          issue_i.is_signed);
                        s_next.cnt  = CNT_W'(FULL_ITERS);
                    end
                end
            end
            st_iter:
            begin
                if (s_reg.op == quotient_op)
                begin
                    // one restoring step per clock
                    // one extra bit keeps large divisors from wrapping
                    trial = {s_reg.rem[32:0], s_reg.quo[31]}
                            - {2'b00, s_reg.opnd};
                    if (!trial[33])
                        s_next.rem = trial[32:0];
                    else
                        s_next.rem = {s_reg.rem[31:0], s_reg.quo[31]};
                    s_next.quo = {s_reg.quo[30:0], !trial[33]};
                end
                else
                begin
                    sum = {1'b0, s_reg.rem[31:0]}
                          + (s_reg.quo[0] ? {1'b0, s_reg.opnd} : 33'h0);
                    s_next.rem = {1'b0, sum[32:1]};
                    s_next.quo = {sum[0], s_reg.quo[31:1]};
                end
                if (s_reg.cnt == CNT_W'(1))
                    s_next.state = st_fix;
                s_next.cnt = s_reg.cnt - CNT_W'(1);
            end
            st_fix:
            begin
                s_next.state = st_idle;
                s_next.done  = 1'b1;
                if (s_reg.op == quotient_op)
                begin
                    // remainder up, quotient down, signs fixed
                    s_next.upper_result_reg = s_reg.neg_rem
                        ? 32'(-s_reg.rem[31:0]) : s_reg.rem[31:0];
                    s_next.bottom_result_reg = s_reg.neg_main
                        ? 32'(-s_reg.quo) : s_reg.quo;
                end
                else
                begin
                    prod = {s_reg.rem[31:0], s_reg.quo};
                    if (s_reg.neg_main)
                        prod = 64'(-prod);
                    if (s_reg.op == gpr_product_op)
                    begin
                        s_next.gpr.valid = 1'b1;
                        s_next.gpr.data  = prod[31:0];
                    end
                    else
                    begin
                        {s_next.upper_result_reg, s_next.bottom_result_reg} =
                            fold(s_reg.op, prod, {s_reg.upper_result_reg,
                                                  s_reg.bottom_result_reg});
                    end
                end
            end
            default:
            begin
                s_next.state = st_idle;
            end
        endcase
    end

    // all unit state outside the multiplier pipe in one register
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s_reg       <= '0;
            s_reg.state <= st_idle;
            s_reg.op    <= full_product_op;
        end
        else
            s_reg <= s_next;
    end

    assign upper_result_o  = s_reg.upper_result_reg;
    assign bottom_result_o = s_reg.bottom_result_reg;
    assign gpr_result_o    = s_reg.gpr;
    assign done_o          = s_reg.done;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    property p_engine_moves;
        s_reg.state == st_iter |=>
            (s_reg.cnt == $past(s_reg.cnt) - CNT_W'(1))
            || (s_reg.state == st_fix);
    endproperty
    a_engine_moves: assert property (p_engine_moves)
        else $error("iterative engine failed to advance");

    property p_idle_no_stall;
        !busy_o |-> !stall_o;
    endproperty
    a_idle_no_stall: assert property (p_idle_no_stall)
        else $error("stall raised while idle");

    property p_back_to_back;
        (!ITERATIVE_ONLY && accept && issue_i.op == gpr_product_op)
        ##1 (accept && issue_i.op == gpr_product_op)
        |-> ##4 gpr_result_o.valid ##1 gpr_result_o.valid;
    endproperty
    a_back_to_back: assert property (p_back_to_back)
        else $error("back-to-back products not both delivered");

    property p_div_full;
        (accept && issue_i.op == quotient_op && !issue_i.is_signed
         && issue_i.dividend_operand[31]) |-> ##34 done_o;
    endproperty
    a_div_full: assert property (p_div_full)
        else $error("full divide did not end after 34 clocks");

    property p_div_early8;
        (!ITERATIVE_ONLY && accept && issue_i.op == quotient_op
         && !issue_i.is_signed
         && issue_i.dividend_operand[31:8] == 24'h000000)
        |=> !done_o[*7] ##4 done_o;
    endproperty
    a_div_early8: assert property (p_div_early8)
        else $error("8-bit dividend did not end after 11 clocks");

    property p_div_stall;
        (accept && issue_i.op == quotient_op)
        |=> (stall_o || !issue_i.valid)[*8];
    endproperty
    a_div_stall: assert property (p_div_stall)
        else $error("issue taken during a divide");

    property p_iter_mul;
        (ITERATIVE_ONLY && accept && issue_i.op != quotient_op)
        |-> ##34 done_o;
    endproperty
    a_iter_mul: assert property (p_iter_mul)
        else $error("iterative product latency is not 34");

    property p_mul_latency;
        (!ITERATIVE_ONLY && accept && issue_i.op == gpr_product_op)
        |-> ##5 (gpr_result_o.valid && gpr_result_o.data ==
            $past(issue_i.dividend_operand * issue_i.second_operand, 5));
    endproperty
    a_mul_latency: assert property (p_mul_latency)
        else $error("product wrong or not five clocks after issue");

    property p_div_result;
        (!ITERATIVE_ONLY && accept && issue_i.op == quotient_op
         && !issue_i.is_signed
         && issue_i.dividend_operand[31:8] == 24'h000000
         && issue_i.second_operand != 32'h00000000)
        |-> ##11 (bottom_result_o == $past(issue_i.dividend_operand
                                        / issue_i.second_operand, 11)
                  && upper_result_o == $past(issue_i.dividend_operand
                                        % issue_i.second_operand, 11));
    endproperty
    a_div_result: assert property (p_div_result)
        else $error("quotient or remainder misplaced");

    property p_accumulate;
        (pipe_out.valid && pipe_out.op == product_accumulate_op)
        |=> {upper_result_o, bottom_result_o} ==
            $past({upper_result_o, bottom_result_o} + pipe_out.prod);
    endproperty
    a_accumulate: assert property (p_accumulate)
        else $error("accumulate did not add the product");

    c_div_early: cover property (accept && issue_i.op == quotient_op
        && early_skip(issue_i.dividend_operand, issue_i.is_signed)
           == 6'(SKIP_16));
    c_b2b: cover property (pipe_take ##1 pipe_take ##1 pipe_take);
    c_deduct: cover property (pipe_out.valid
        && pipe_out.op == product_deduct_op);
    c_div_stall: cover property (stall_o ##1 stall_o);

endmodule

// [bench/issue_source.sv]
// integer-pipe issue model: presents requests and holds them while stalled
module issue_source
(
    input  wire logic     mclk_i,
    input  wire logic     stall_i,
    output pq_pkg::issue_t issue_o,
    output int            cyc_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import pq_pkg::*;

    // start idle; edge counter lets the bench time every answer
    initial
    begin
        issue_o = '0;
        cyc_o = 0;
    end

    always @(posedge mclk_i)
        cyc_o <= cyc_o + 1;

    // hold while stalled
    // request changes only at a falling edge and stands until taken
    task automatic send(input issue_t req, output int taken);
        issue_o = req;
        #1;
        while (stall_i !== 1'b0)
        begin
            @(negedge mclk_i);
            #1;
        end
        @(negedge mclk_i);
        taken = cyc_o;
    endtask

    // released fields show the inverse so a stale value cannot pass
    task automatic release_bus();
        issue_t tmp;
        tmp = ~issue_o;
        tmp.valid = 1'b0;
        issue_o = tmp;
    endtask
endmodule

// [bench/tb_product_quotient_unit.sv]
// self-checking bench of the product/quotient unit
module tb_product_quotient_unit;
    timeunit 1ns;
    timeprecision 1ps;
    import pq_pkg::*;

    typedef struct
    {
        int          due;
        op_t         op;
        logic [63:0] pair;
        logic [31:0] data;
    } note_t;

    logic        mclk_i;
    logic        rst_n_i;
    issue_t      issue;
    logic        stall;
    logic        busy;
    logic        done;
    logic [31:0] up;
    logic [31:0] bot;
    gpr_t        gpr;
    int          cyc;
    int          failures = 0;
    int          checks_done = 0;
    int          seed = 32'h23a2;
    note_t       q[$];
    note_t       mon_n;
    logic [63:0] pair_m;
    logic        it_busy;
    logic        it_done;
    logic        it_busy_d = 1'b0;
    int          it_start = 0;
    op_t         ops[4] = '{full_product_op, product_accumulate_op,
                            product_deduct_op, gpr_product_op};

    product_quotient_unit i_product_quotient_unit
    (
        .mclk_i          (mclk_i),
        .rst_n_i         (rst_n_i),
        .issue_i         (issue),
        .stall_o         (stall),
        .busy_o          (busy),
        .upper_result_o  (up),
        .bottom_result_o (bot),
        .gpr_result_o    (gpr),
        .done_o          (done)
    );

    issue_source i_issue_source
    (
        .mclk_i  (mclk_i),
        .stall_i (stall),
        .issue_o (issue),
        .cyc_o   (cyc)
    );

    // reduced-area build watches the same issue stream; it ignores the
    // standard unit's stall and takes whatever stands when it is idle
    product_quotient_unit #(
        .ITERATIVE_ONLY (1'b1)
    ) i_product_quotient_unit_iter
    (
        .mclk_i          (mclk_i),
        .rst_n_i         (rst_n_i),
        .issue_i         (issue),
        .stall_o         (),
        .busy_o          (it_busy),
        .upper_result_o  (),
        .bottom_result_o (),
        .gpr_result_o    (),
        .done_o          (it_done)
    );

    // reduced-area latency: done 33 clocks after the taking edge
    always @(negedge mclk_i)
    begin
        if (rst_n_i === 1'b1 && it_busy === 1'b1 && it_busy_d !== 1'b1)
            it_start = cyc;
        if (rst_n_i === 1'b1 && it_done !== 1'b0)
            chk(64'(cyc - it_start), 64'(ITER_LAT_CYC - 1));
        it_busy_d = it_busy;
    end

    // free-running 100 MHz clock
    initial
    begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
        begin
            $display("[ PASS ]");
        end
        else
        begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // 64-bit product, operands widened by signedness
    function automatic logic [63:0] mul(input logic s, input logic [31:0] a,
                                        input logic [31:0] b);
        logic [63:0] x;
        logic [63:0] y;
        x = s ? {{32{a[31]}}, a} : {32'h0, a};
        y = s ? {{32{b[31]}}, b} : {32'h0, b};
        return x * y;
    endfunction

    function automatic int skip(input logic s, input logic [31:0] a);
        if (s ? (&a[31:7] || ~|a[31:7]) : ~|a[31:8])
            return SKIP_8;
        if (s ? (&a[31:15] || ~|a[31:15]) : ~|a[31:16])
            return SKIP_16;
        if (s ? (&a[31:23] || ~|a[31:23]) : ~|a[31:24])
            return SKIP_24;
        return 0;
    endfunction

    // issue one op and note its expected result and due cycle
    task automatic issue_op(input op_t op, input logic s, input logic [31:0] a,
                            input logic [31:0] b, output int k);
        issue_t      r;
        note_t       n;
        logic [63:0] p;
        r.valid = 1'b1;
        r.op = op;
        r.is_signed = s;
        r.dividend_operand = a;
        r.second_operand = b;
        i_issue_source.send(r, k);
        p = mul(s, a, b);
        n.op = op;
        n.data = p[31:0];
        n.due = k + MUL_LAT_CYC - 1;
        case (op)
            product_accumulate_op: pair_m = pair_m + p;
            product_deduct_op:     pair_m = pair_m - p;
            full_product_op:       pair_m = p;
            quotient_op:
            begin
                if (s)
                    pair_m = {32'($signed(a) % $signed(b)),
                              32'($signed(a) / $signed(b))};
                else
                    pair_m = {a % b, a / b};
                n.due = k + FULL_ITERS - skip(s, a) + 1;
            end
            default: ;
        endcase
        n.pair = pair_m;
        q.push_back(n);
    endtask

    // monitor: oldest note is judged on its due cycle, stray strobes fail
    always @(negedge mclk_i)
    begin
        if (rst_n_i === 1'b1 && q.size() > 0 && q[0].due == cyc)
        begin
            mon_n = q.pop_front();
            chk({up, bot}, mon_n.pair);
            if (mon_n.op == gpr_product_op)
                chk({31'h0, gpr.valid, gpr.data}, {31'h0, 1'b1, mon_n.data});
            if (mon_n.op == quotient_op)
                chk({63'h0, done}, 64'h1);
        end
        else if (rst_n_i === 1'b1 && (gpr.valid !== 1'b0 || done !== 1'b0))
            chk({62'h0, gpr.valid, done}, 64'h0);
    end

    // hang guard well above the expected run length
    always @(posedge mclk_i)
    begin
        if (cyc == 20000)
        begin
            failures++;
            test_done();
        end
    end

    initial
    begin
        int          k;
        int          k2;
        int          prev;
        logic        s;
        logic [31:0] a;
        logic [31:0] b;
        int          sh;
        rst_n_i = 1'b0;
        pair_m = '0;
        repeat (2) @(negedge mclk_i);
        rst_n_i = 1'b1;
        chk({up, bot}, 64'h0);
        chk({60'h0, busy, stall, done, gpr.valid}, 64'h0);
        $display("test reset done");
        // back-to-back products of every kind, random operands
        prev = 0;
        for (int i = 0; i < 12; i++)
        begin
            issue_op(ops[i % 4], 1'($random(seed)), 32'($random(seed)),
                     32'($random(seed)), k);
            if (i > 0)
                chk(64'(k), 64'(prev + 1));
            prev = k;
        end
        i_issue_source.release_bus();
        repeat (6) @(negedge mclk_i);
        $display("test products done");
        // divides of each dividend width, each chased by a stalled product
        for (int w = 0; w < 8; w++)
        begin
            s = w[0];
            sh = 24 - 8 * (w >> 1);
            a = 32'($random(seed));
            a = s ? 32'($signed(a << sh) >>> sh) : a >> sh;
            b = (32'($random(seed)) & 32'h0FFF) | 32'h2;
            issue_op(quotient_op, s, a, b, k);
            issue_op(gpr_product_op, s, a, b, k2);
            chk(64'(k2), 64'(k + FULL_ITERS - skip(s, a) + 2));
        end
        i_issue_source.release_bus();
        repeat (40) @(negedge mclk_i);
        chk(64'(q.size()), 64'h0);
        $display("test divides done");
        test_done();
    end
endmodule
